// file: pbs_pkg.sv
`default_nettype none
package pbs_pkg;
	localparam int DATA_W = 36;
	localparam int BYTE_W = 9;
	localparam int DEPTH = 64;
	localparam int ADDR_W = 6;
	localparam int PTR_W = 7;
	localparam int AE_OFFSET_DEF = 8;
	localparam int AF_OFFSET_DEF = 8;
	////////////////////////////////////////////////////////////////////////
	// Port B size select codes {hi, lo}
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h2;
	localparam logic [1:0] SIZE_MAIL = 2'h3;
	// Swap mode codes {hi, lo}
	localparam logic [1:0] SWAP_NONE = 2'h0;
	localparam logic [1:0] SWAP_FULL = 2'h1;
	localparam logic [1:0] SWAP_WORD = 2'h2;
	localparam logic [1:0] SWAP_BYTE = 2'h3;
	// Last lane index of a long word
	localparam logic [1:0] LAST_WORD_LANE = 2'h1;
	localparam logic [1:0] LAST_BYTE_LANE = 2'h3;
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic chipSelN;
		logic direction;
		logic enable;
	} pbs_strobe_t;
	typedef struct packed {
		logic sizeSelectHi;
		logic sizeSelectLo;
		logic swapSelHi;
		logic swapSelLo;
		logic bigEndian;
		logic parityGenB;
	} pbs_cfg_t;
	typedef struct packed {
		logic [PTR_W-1:0] wrPtr;
		logic [PTR_W-1:0] rdPtr;
		logic [PTR_W-1:0] wrPtrSeen;
		logic [PTR_W-1:0] rdPtrSeen;
		logic [1:0] lane;
		logic [DATA_W-1:0] mail1;
		logic [DATA_W-1:0] mail2;
		logic [DATA_W-1:0] dataAOut;
		logic [DATA_W-1:0] dataBOut;
	} pbs_state_t;
endpackage
`default_nettype wire

// file: pbs_ram.sv
`default_nettype none
module pbs_ram #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Storage carries no reset; only the read register does
	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule
`default_nettype wire

// file: pbs_portb_fifo.sv
`default_nettype none
// Overview of operation
// - Byte reads follow swap mode then endianness, giving the tabled byte orders.
// - Empty flag rises the cycle after a write into an empty FIFO reaches read side.
// - In word or byte size, empty drops only on reading the final lane.
// - Both size selects low select long-word FIFO reads.
// - Almost-empty rises one cycle after the qualifying write reaches the read side.
// - Almost-full rises one cycle after the qualifying read reaches the write side.
// - A long word counts as removed at the edge reading its final lane.
// - Port-A-bound mailbox keeps its word after being read.
// - With parity generation off, stored parity bits pass through unchanged.
// - Both size selects high put the port-B-bound mailbox on all 36 lines.
// - Lanes outside the active one carry undefined data; here they read zero.
module pbs_portb_fifo #(
	parameter int AE_OFFSET = pbs_pkg::AE_OFFSET_DEF,
	parameter int AF_OFFSET = pbs_pkg::AF_OFFSET_DEF
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire pbs_pkg::pbs_strobe_t portACtl,
	input wire logic mailboxSelA,
	input wire logic [pbs_pkg::DATA_W-1:0] dataAIn,
	output var logic [pbs_pkg::DATA_W-1:0] dataAOut,
	output logic dataAOe,
	input wire pbs_pkg::pbs_strobe_t portBCtl,
	input wire pbs_pkg::pbs_cfg_t portBCfg,
	input wire logic [pbs_pkg::DATA_W-1:0] dataBIn,
	output var logic [pbs_pkg::DATA_W-1:0] dataBOut,
	output logic dataBOe,
	output logic emptyFlagN,
	output logic almostEmptyN,
	output logic almostFullN,
	output logic fullFlagN
);
	import pbs_pkg::*;

	pbs_state_t st;
	pbs_state_t next_st;
	logic [DATA_W-1:0] ramData;
	logic [PTR_W-1:0] countR;
	logic [PTR_W-1:0] countW;
	logic [PTR_W-1:0] next_rdPtr;
	logic [1:0] sizeCode;
	logic [1:0] swapCode;
	logic fifoWrite;
	logic mail1Write;
	logic mail2Write;
	logic portARead;
	logic portBRead;
	logic fifoRead;
	logic lastLane;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [DATA_W-1:0] swapWord(input logic [DATA_W-1:0] w,
		input logic [1:0] code);
		logic [BYTE_W-1:0] a, b, c, d;
		{a, b, c, d} = w;
		unique case (code)
			SWAP_NONE: swapWord = {a, b, c, d};
			SWAP_FULL: swapWord = {d, c, b, a};
			SWAP_WORD: swapWord = {c, d, a, b};
			SWAP_BYTE: swapWord = {b, a, d, c};
		endcase
	endfunction

	// Odd parity per byte into its top bit when generation is on
	function automatic logic [DATA_W-1:0] applyParity(input logic [DATA_W-1:0] w,
		input logic gen);
		applyParity = w;
		if (gen) begin
			for (int i = 0; i < 4; i++) begin
				applyParity[i*BYTE_W+8] = ~^w[i*BYTE_W +: 8];
			end
		end
	endfunction

	function automatic logic [DATA_W-1:0] laneData(input logic [DATA_W-1:0] w,
		input logic [1:0] size, input logic [1:0] lane, input logic big);
		logic [1:0] idx;
		laneData = '0;
		idx = big ? lane : 2'h3 - lane;
		unique case (size)
			SIZE_WORD: begin
				if (big) begin
					laneData[35:18] = lane[0] ? w[17:0] : w[35:18];
				end else begin
					laneData[17:0] = lane[0] ? w[35:18] : w[17:0];
				end
			end
			SIZE_BYTE: begin
				if (big) begin
					laneData[35:27] = w[(3-idx)*BYTE_W +: BYTE_W];
				end else begin
					laneData[8:0] = w[(3-idx)*BYTE_W +: BYTE_W];
				end
			end
			default: laneData = w;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign sizeCode = {portBCfg.sizeSelectHi, portBCfg.sizeSelectLo};
	assign swapCode = {portBCfg.swapSelHi, portBCfg.swapSelLo};
	assign countR = st.wrPtrSeen - st.rdPtr;
	assign countW = st.wrPtr - st.rdPtrSeen;
	assign emptyFlagN = countR != '0;
	assign almostEmptyN = countR > PTR_W'(AE_OFFSET);
	assign almostFullN = countW < PTR_W'(DEPTH - AF_OFFSET);
	assign fullFlagN = countW != PTR_W'(DEPTH);
	assign dataAOut = st.dataAOut;
	assign dataBOut = st.dataBOut;
	assign dataAOe = !portACtl.chipSelN && !portACtl.direction;
	assign dataBOe = !portBCtl.chipSelN && !portBCtl.direction;

	// Writes into a full FIFO are dropped
	assign fifoWrite = !portACtl.chipSelN && portACtl.direction && !mailboxSelA
		&& portACtl.enable && fullFlagN;
	assign mail1Write = !portACtl.chipSelN && portACtl.direction && mailboxSelA
		&& portACtl.enable;
	assign portARead = dataAOe && portACtl.enable;
	assign mail2Write = !portBCtl.chipSelN && portBCtl.direction && portBCtl.enable;
	assign portBRead = dataBOe && portBCtl.enable;
	// Reads of an empty FIFO are ignored
	assign fifoRead = portBRead && sizeCode != SIZE_MAIL && emptyFlagN;
	always_comb begin
		unique case (sizeCode)
			SIZE_WORD: lastLane = st.lane == LAST_WORD_LANE;
			SIZE_BYTE: lastLane = st.lane == LAST_BYTE_LANE;
			default: lastLane = 1'b1;
		endcase
	end
	assign next_rdPtr = (fifoRead && lastLane) ? st.rdPtr + 1'b1 : st.rdPtr;

	pbs_ram #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.AW(ADDR_W)
	) ram (
		.clock(clock),
		.arst_n(arst_n),
		.wrEn(fifoWrite),
		.wrAddr(st.wrPtr[ADDR_W-1:0]),
		.wrData(dataAIn),
		.rdAddr(next_rdPtr[ADDR_W-1:0]),
		.rdData(ramData)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		// One register stage stands in for each pointer crossing
		next_st.wrPtrSeen = st.wrPtr;
		next_st.rdPtrSeen = st.rdPtr;
		next_st.rdPtr = next_rdPtr;
		if (fifoWrite) begin
			next_st.wrPtr = st.wrPtr + 1'b1;
		end
		if (mail1Write) begin
			next_st.mail1 = dataAIn;
		end
		if (mail2Write) begin
			next_st.mail2 = dataBIn;
		end
		if (portARead) begin
			next_st.dataAOut = st.mail2;
		end
		if (fifoRead) begin
			next_st.lane = lastLane ? 2'h0 : st.lane + 1'b1;
			// Parity before lane select keeps idle lanes at zero
			next_st.dataBOut = laneData(applyParity(swapWord(ramData, swapCode),
				portBCfg.parityGenB), sizeCode, st.lane, portBCfg.bigEndian);
		end else if (portBRead && sizeCode == SIZE_MAIL) begin
			next_st.dataBOut = applyParity(st.mail1, portBCfg.parityGenB);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence byteStep;
		fifoRead && sizeCode == SIZE_BYTE && !lastLane;
	endsequence
	sequence byteLast;
		fifoRead && sizeCode == SIZE_BYTE && lastLane;
	endsequence

	chk_swap_first: assert property (fifoRead && sizeCode == SIZE_BYTE && st.lane == 2'h0
		&& swapCode == SWAP_FULL && portBCfg.bigEndian && !portBCfg.parityGenB
		|=> dataBOut[35:27] == $past(ramData[8:0]))
		else $error("byte swap order wrong");
	chk_empty_rise: assert property (fifoWrite && !emptyFlagN && !fifoRead
		|-> ##2 emptyFlagN)
		else $error("empty flag did not rise in time");
	chk_empty_partial: assert property (byteStep |=> emptyFlagN)
		else $error("empty flag fell on partial read");
	chk_long_step: assert property (fifoRead && sizeCode == SIZE_LONG
		|=> st.rdPtr == $past(st.rdPtr) + 1'b1)
		else $error("long read did not advance pointer");
	chk_ae_cause: assert property ($rose(almostEmptyN) |-> $past(fifoWrite, 2))
		else $error("almost empty rose without write");
	chk_af_cause: assert property ($rose(almostFullN)
		|-> $past(fifoRead && lastLane, 2))
		else $error("almost full rose without read");
	chk_lane_hold: assert property (byteStep ##1 byteStep ##1 byteStep ##1 byteLast
		|=> st.rdPtr == $past(st.rdPtr, 4) + 1'b1)
		else $error("four byte reads did not remove one long word");
	chk_mail_hold: assert property (portARead && !mail2Write
		|=> st.mail2 == $past(st.mail2) && dataAOut == $past(st.mail2))
		else $error("mailbox changed by read");
	chk_parity_pass: assert property (portBRead && sizeCode == SIZE_MAIL
		&& !portBCfg.parityGenB |=> dataBOut == $past(st.mail1))
		else $error("parity altered while generation off");
	chk_mail_out: assert property (portBRead && sizeCode == SIZE_MAIL
		|=> dataBOut[7:0] == $past(st.mail1[7:0]))
		else $error("mailbox not driven on port B");
	chk_lane_zero: assert property (fifoRead && sizeCode == SIZE_WORD
		&& portBCfg.bigEndian |=> dataBOut[17:0] == '0)
		else $error("inactive lanes not zero");
	chk_lane_count: assert property (byteStep |=> st.lane == $past(st.lane) + 1'b1
		&& st.rdPtr == $past(st.rdPtr))
		else $error("lane counter did not step");
endmodule
`default_nettype wire

// file: pbs_host_a.sv
`default_nettype none
// Port-A host model for writes and reads; one strobe cycle per request
module pbs_host_a (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic req,
	input wire logic reqDir,
	input wire logic reqMail,
	input wire logic [pbs_pkg::DATA_W-1:0] reqData,
	output pbs_pkg::pbs_strobe_t portACtl,
	output logic mailboxSelA,
	output logic [pbs_pkg::DATA_W-1:0] dataAIn
);
	timeunit 1ns;
	timeprecision 1ps;
	import pbs_pkg::*;
	// Released data flips each cycle so a stale word never looks valid
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			portACtl <= 3'b100;
			mailboxSelA <= 1'b0;
			dataAIn <= '0;
		end else if (req) begin
			portACtl <= {1'b0, reqDir, 1'b1};
			mailboxSelA <= reqMail;
			dataAIn <= reqData;
		end else begin
			portACtl <= 3'b100;
			mailboxSelA <= 1'b0;
			dataAIn <= ~dataAIn;
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pbs_pkg::*;
	logic clock, arst_n, req, reqDir, reqMail, mailboxSelA, dataAOe, dataBOe;
	logic emptyFlagN, almostEmptyN, almostFullN, fullFlagN;
	logic [DATA_W-1:0] reqData, dataAIn, dataAOut, dataBIn, dataBOut, w;
	logic [1:0] sw;
	pbs_strobe_t portACtl, portBCtl;
	pbs_cfg_t portBCfg;
	int fail_count, check_count, cycles;
	logic [DATA_W-1:0] q[$];
	pbs_host_a pbs_host_a_i (.clock(clock), .arst_n(arst_n), .req(req), .reqDir(reqDir),
		.reqMail(reqMail), .reqData(reqData), .portACtl(portACtl),
		.mailboxSelA(mailboxSelA), .dataAIn(dataAIn));
	pbs_portb_fifo pbs_portb_fifo_i (.clock(clock), .arst_n(arst_n), .portACtl(portACtl),
		.mailboxSelA(mailboxSelA), .dataAIn(dataAIn), .dataAOut(dataAOut),
		.dataAOe(dataAOe), .portBCtl(portBCtl), .portBCfg(portBCfg), .dataBIn(dataBIn),
		.dataBOut(dataBOut), .dataBOe(dataBOe), .emptyFlagN(emptyFlagN),
		.almostEmptyN(almostEmptyN), .almostFullN(almostFullN), .fullFlagN(fullFlagN));
	////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Whole run needs under 2000 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			end_sim();
		end
	end
	////////////////////////////////////////
	task automatic end_sim();
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [35:0] got, logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	function automatic logic [35:0] rnd();
		return {4'($urandom), $urandom};
	endfunction
	// Swap code maps to an xor on the byte letter: 0,3,2,1
	function automatic logic [8:0] expByte(logic [35:0] v, logic [1:0] s, logic big, int i);
		logic [1:0] idx;
		logic [1:0] pos;
		idx = big ? 2'(i) : 2'h3 - 2'(i);
		pos = idx ^ (2'h0 - s);
		return v[35 - 9 * int'(pos) -: 9];
	endfunction
	// Odd parity of the low eight bits lands in the top bit of the byte
	function automatic logic [8:0] withParity(logic [8:0] b);
		return {~^b[7:0], b[7:0]};
	endfunction
	// Ends just after the edge at which the FIFO samples the strobe, one edge after the host takes the request
	task automatic hostOp(logic [35:0] d, logic dir, logic mail);
		@(posedge clock);
		req <= 1'b1;
		reqData <= d;
		reqDir <= dir;
		reqMail <= mail;
		@(posedge clock);
		req <= 1'b0;
		#1;
		chk("dataAOe", 36'(dataAOe), 36'(!dir));
		@(posedge clock);
		#1;
	endtask
	task automatic readB(logic [1:0] size, logic [1:0] s, logic big);
		@(posedge clock);
		portBCtl <= 3'b001;
		portBCfg <= {size, s, big, 1'b0};
		#1;
		chk("dataBOe", 36'(dataBOe), 36'h1);
		@(posedge clock);
		portBCtl <= 3'b100;
		#1;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h5ed0));
		{arst_n, req, reqDir, reqMail, reqData, dataBIn, portBCfg} = '0;
		portBCtl = 3'b100;
		{fail_count, check_count, cycles} = '0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		chk("resetFlags", 36'({emptyFlagN, almostEmptyN, almostFullN, fullFlagN}), 36'h3);
		for (int m = 0; m < 8; m++) begin
			w = rnd();
			hostOp(w, 1'b1, 1'b0);
			chk("emptyEarly", 36'(emptyFlagN), 36'h0);
			cyc(1);
			chk("emptyRise", 36'(emptyFlagN), 36'h1);
			for (int i = 0; i < 4; i++) begin
				readB(SIZE_BYTE, m[2:1], m[0]);
				chk("byteLane", 36'(m[0] ? dataBOut[35:27] : dataBOut[8:0]),
					36'(expByte(w, m[2:1], m[0], i)));
				chk("emptyByte", 36'(emptyFlagN), 36'(i < 3));
			end
		end
		w = rnd();
		hostOp(w, 1'b1, 1'b0);
		cyc(3);
		for (int i = 0; i < 2; i++) begin
			readB(SIZE_WORD, SWAP_NONE, 1'b1);
			chk("wordLane", 36'(dataBOut[35:18]), 36'(w[35 - 18 * i -: 18]));
			chk("emptyWord", 36'(emptyFlagN), 36'(i == 0));
		end
		// 65th write must be dropped: the queue holds only 64
		for (int i = 0; i < 65; i++) begin
			w = rnd();
			hostOp(w, 1'b1, 1'b0);
			if (i < 64) q.push_back(w);
			if (i == 7 || i == 8) begin
				cyc(4);
				chk("almostEmpty", 36'(almostEmptyN), 36'(i == 8));
			end
			if (i == 54 || i == 55) begin
				cyc(4);
				chk("almostFull", 36'(almostFullN), 36'(i == 54));
			end
		end
		cyc(3);
		chk("full", 36'(fullFlagN), 36'h0);
		for (int i = 0; i < 64; i++) begin
			sw = 2'($urandom);
			readB(SIZE_LONG, sw, 1'b1);
			w = q.pop_front();
			chk("longData", dataBOut, {expByte(w, sw, 1'b1, 0), expByte(w, sw, 1'b1, 1),
				expByte(w, sw, 1'b1, 2), expByte(w, sw, 1'b1, 3)});
			if (i == 7 || i == 8) begin
				cyc(3);
				chk("almostFullRise", 36'(almostFullN), 36'(i == 8));
			end
		end
		cyc(3);
		chk("emptyAfterAll", 36'(emptyFlagN), 36'h0);
		w = rnd();
		hostOp(w, 1'b1, 1'b1);
		cyc(2);
		readB(SIZE_MAIL, SWAP_NONE, 1'b1);
		chk("mailToB", dataBOut, w);
		w = rnd();
		@(posedge clock);
		portBCtl <= 3'b011;
		dataBIn <= w;
		@(posedge clock);
		portBCtl <= 3'b100;
		dataBIn <= ~w;
		repeat (2) begin
			hostOp(rnd(), 1'b0, 1'b1);
			chk("mailToA", dataAOut, w);
		end
		// Back-to-back byte reads, little-endian, parity generated
		w = rnd();
		hostOp(w, 1'b1, 1'b0);
		cyc(2);
		@(posedge clock);
		portBCtl <= 3'b001;
		portBCfg <= {SIZE_BYTE, SWAP_WORD, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			if (i == 3) begin
				portBCtl <= 3'b100;
			end
			#1;
			chk("burstByte", 36'(dataBOut[8:0]),
				36'(withParity(expByte(w, SWAP_WORD, 1'b0, i))));
			chk("idleLanes", 36'(dataBOut[35:9]), 36'h0);
			chk("emptyBurst", 36'(emptyFlagN), 36'(i < 3));
		end
		chk("dataBOeIdle", 36'(dataBOe), 36'h0);
		end_sim();
	end
endmodule
`default_nettype wire
